// file: design/idr_pkg.sv
/*
 * idr_pkg: constants and carriers for the interrupt and dma routing block.
 * assumes: one 10 MHz system clock; config index/data port on an 8-bit io bus.
 */
package idr_pkg;

    // ************************************************************
    // configuration space indices
    // ************************************************************
    localparam logic [7:0] IDX_LDN     = 8'h07;
    localparam logic [7:0] IDX_OSC     = 8'h24;
    localparam logic [7:0] IDX_CFG_LO  = 8'h26;
    localparam logic [7:0] IDX_CFG_HI  = 8'h27;
    localparam logic [7:0] IDX_ACT     = 8'h30;
    localparam logic [7:0] IDX_BASE_HI = 8'h60;
    localparam logic [7:0] IDX_BASE_LO = 8'h61;
    localparam logic [7:0] IDX_IRQ     = 8'h70;
    localparam logic [7:0] IDX_DMA     = 8'h74;

    // ************************************************************
    // logical devices
    // ************************************************************
    localparam int         NUM_LD    = 8;
    localparam logic [3:0] NUM_LD_4  = 4'h8;
    localparam int         LD_FDC    = 0;
    localparam int         LD_PAR    = 3;
    localparam int         LD_UART1  = 4;
    localparam int         LD_UART2  = 5;
    localparam int         LD_KBD    = 7;
    localparam logic [7:0] IMPL_LD   = 8'hB9;
    localparam logic [7:0] RELOC_LD  = 8'h39;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [3:0]  IRQ_RST      = 4'h0;
    localparam logic [3:0]  IRQ_RST_FDC  = 4'h6;
    localparam logic [2:0]  DMA_RST      = 3'h4;
    localparam logic [2:0]  DMA_RST_FDC  = 3'h2;
    localparam logic [11:0] BASE_RST     = 12'h000;
    localparam logic [15:0] CFG_PORT_LO  = 16'h03F0;
    localparam logic [15:0] CFG_PORT_HI  = 16'h0370;

    // ************************************************************
    // decode limits and fields
    // ************************************************************
    localparam logic [11:0] BASE_MIN     = 12'h100;
    localparam logic [11:0] BASE_MAX     = 12'hFF8;
    localparam logic [11:0] PAR_BASE_MAX = 12'hFFC;
    localparam logic [11:0] SPAN8_MASK   = 12'h007;
    localparam logic [11:0] SPAN4_MASK   = 12'h003;
    localparam logic [11:0] SPAN2_MASK   = 12'h001;
    localparam logic [15:0] KBD_DATA     = 16'h0060;
    localparam logic [15:0] KBD_CMD      = 16'h0064;
    localparam int          OSC_QUAL16   = 6;
    localparam logic [15:0] IRQ_PAR_MASK = 16'h1CF8;
    localparam logic [15:0] IRQ_ALL_MASK = 16'hFFFF;
    localparam logic [15:0] IRQ_SMI_BIT  = 16'h0004;
    localparam logic [3:0]  IRQ_NONE     = 4'h0;
    localparam logic [2:0]  DMA_CH_MIN   = 3'h1;
    localparam logic [2:0]  DMA_CH_MAX   = 3'h3;
    localparam logic [2:0]  ECP_FIFO     = 3'h2;
    localparam logic [2:0]  ECP_ECP      = 3'h3;
    localparam logic [2:0]  ECP_TEST     = 3'h6;

    // ************************************************************
    // carriers
    // ************************************************************
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } idr_io_t;

    typedef struct packed {
        logic       floppy_dma_irq_gate;
        logic       fdc_power_down;
        logic       parallel_irq_enable;
        logic       ecp_active;
        logic [2:0] ecp_mode;
        logic       ecp_service_interrupt;
        logic       ecp_dma_enable;
        logic [3:0] uart1_int_enable_reg;
        logic       uart1_aux_output_two;
        logic [3:0] uart2_int_enable_reg;
        logic       uart2_aux_output_two;
    } idr_gate_t;

endpackage

// file: design/idr_route_slice.sv
/*
 * idr_route_slice: one logical device's irq level and dma channel steering.
 * assumes: selects come from registers of the top, enables from its gate logic; purely combinational.
 */
`timescale 1ns/100ps
module idr_route_slice
    import idr_pkg::*;
(
    input  wire logic [3:0]  i_irq_sel,
    input  wire logic        i_irq_en,
    input  wire logic        i_irq_req,
    input  wire logic [2:0]  i_dma_sel,
    input  wire logic        i_dma_en,
    input  wire logic        i_dma_req,
    output logic      [15:0] o_irq_use,
    output logic      [15:0] o_irq_lvl,
    output logic      [3:0]  o_dma_use,
    output logic      [3:0]  o_dma_lvl
);

    wire irq_on = i_irq_en && (i_irq_sel != IRQ_NONE);
    wire dma_ok = (i_dma_sel >= DMA_CH_MIN) && (i_dma_sel <= DMA_CH_MAX);
    wire dma_on = i_dma_en && dma_ok;

    assign o_irq_use = irq_on ? (16'h0001 << i_irq_sel) : 16'h0000;
    assign o_irq_lvl = o_irq_use & {16{i_irq_req}};
    assign o_dma_use = dma_on ? (4'h1 << i_dma_sel[1:0]) : 4'h0;
    assign o_dma_lvl = o_dma_use & {4{i_dma_req}};

endmodule

// file: design/idr_routing.sv
/*
 * idr_routing: plug-and-play config space slice holding per-device irq level
 * and dma channel selects, gating each device's requests onto shared pins.
 * assumes: io bus strobes are one-cycle and synchronous to i_clk_sys; device-local
 * gate bits arrive already decoded from the floppy, parallel and uart blocks.
 */
`timescale 1ns/100ps
// How it works
// - low nibble picks level, zero none
// - irq select resets zero, floppy six
// - routed irqs active-high, smi active low
// - floppy irq needs level and gate bit
// - parallel irq needs enable or ecp irq mode; in ecp also service clear
// - uart irq needs enable bits and uart_aux_output_two
// - unused irq pins float
// - parallel irq mode limits usable levels
// - dma select low three bits, 1-3 valid
// - dma select resets four, floppy two
// - dma needs valid channel plus gate
// - unused dma request pins float
// - floppy gate bits kill irq and dack; others kill only one
// - floppy gate off or powerdown floats
// - uart uart_aux_output_two low floats its irq
// - spp/epp parallel enable low floats irq
// - ecp mode table steers irq; dma needs ecp active and dma enable
// - second uart base via 0x60/0x61
// - keyboard fixed at 60 and 64
// - index/data port relocatable via 0x26/0x27
// - strap picks initial config port
// - 12-bit decode, optional 16-bit qualify
// - activate and power bits are one
// - bad base ignored, unused indices zero
module idr_routing
    import idr_pkg::*;
(
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst_n,
    input  wire logic        i_soft_rst,
    input  wire idr_io_t     i_io,
    input  wire idr_gate_t   i_gates,
    input  wire logic        i_config_port_strap,
    input  wire logic        i_serial_irq_mode,
    input  wire logic        i_smi_enable,
    input  wire logic        i_smi_req,
    input  wire logic [7:0]  i_dev_irq,
    input  wire logic [7:0]  i_dev_drq,
    input  wire logic [3:1]  i_dack_n,
    output logic      [7:0]  o_io_rdata,
    output logic             o_io_rdata_valid,
    output logic      [15:0] o_irq,
    output logic      [15:0] o_irq_oe_n,
    output logic      [3:1]  o_dma_request_pin,
    output logic      [3:1]  o_dma_request_oe_n,
    output logic             o_sys_mgmt_int_n,
    output logic      [7:0]  o_dev_dack,
    output logic      [7:0]  o_dev_hit,
    output logic      [7:0]  o_dev_active
);

    // ************************************************************
    // decode helpers
    // ************************************************************
    function automatic logic addr_hit(input logic [15:0] a, input logic [11:0] base,
                                      input logic [11:0] mask, input logic q16);
        addr_hit = ((a[11:0] & ~mask) == (base & ~mask)) && (!q16 || a[15:12] == 4'h0);
    endfunction

    function automatic logic base_ok(input int ld, input logic [11:0] base);
        logic [11:0] top;
        logic [11:0] mask;
        top  = (ld == LD_PAR) ? PAR_BASE_MAX : BASE_MAX;
        mask = (ld == LD_PAR) ? SPAN4_MASK : SPAN8_MASK;
        base_ok = (base >= BASE_MIN) && (base <= top) && ((base & mask) == 12'h000);
    endfunction

    // ************************************************************
    // configuration state
    // ************************************************************
    logic [7:0]  index_reg;
    logic [3:0]  ldn_reg;
    logic [7:0]  osc_reg;
    logic [15:0] cfg_base_reg;
    logic        strap_done_reg;
    logic [7:0]  act_reg;
    logic [11:0] base_reg    [NUM_LD];
    logic [3:0]  irq_sel_reg [NUM_LD];
    logic [2:0]  dma_sel_reg [NUM_LD];

    wire         qual16    = osc_reg[OSC_QUAL16];
    wire         cfg_sel   = addr_hit(i_io.addr, cfg_base_reg[11:0], SPAN2_MASK, qual16);
    wire         idx_wr    = cfg_sel && !i_io.addr[0] && i_io.wr;
    wire         dat_wr    = cfg_sel && i_io.addr[0] && i_io.wr;
    wire         cfg_rd    = cfg_sel && i_io.rd;
    wire [2:0]   cur_ld    = ldn_reg[2:0];
    wire         ld_ok     = (ldn_reg < NUM_LD_4) && IMPL_LD[cur_ld];
    wire         ld_reloc  = (ldn_reg < NUM_LD_4) && RELOC_LD[cur_ld];
    wire [15:0]  cfg_next  = {cfg_base_reg[15:1], 1'b0};

    // ************************************************************
    // register writes
    // ************************************************************
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            index_reg <= 8'h00;
            ldn_reg   <= 4'h0;
            osc_reg   <= 8'h00;
        end else begin
            if (idx_wr)
                index_reg <= i_io.wdata;
            if (dat_wr && index_reg == IDX_LDN)
                ldn_reg <= i_io.wdata[3:0];
            if (dat_wr && index_reg == IDX_OSC)
                osc_reg <= i_io.wdata;
        end
    end

    // strap is caught on the first clock after release, never under reset
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            cfg_base_reg   <= CFG_PORT_LO;
            strap_done_reg <= 1'b0;
        end else if (!strap_done_reg) begin
            cfg_base_reg   <= i_config_port_strap ? CFG_PORT_HI : CFG_PORT_LO;
            strap_done_reg <= 1'b1;
        end else if (dat_wr && index_reg == IDX_CFG_LO) begin
            cfg_base_reg <= {cfg_next[15:8], i_io.wdata[7:1], 1'b0};
        end else if (dat_wr && index_reg == IDX_CFG_HI) begin
            cfg_base_reg <= {i_io.wdata, cfg_next[7:0]};
        end
    end

    // one bit serves as both activate and power control, so they cannot diverge
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n || i_soft_rst)
            act_reg <= 8'h00;
        else if (dat_wr && ld_ok && index_reg == IDX_ACT)
            act_reg[cur_ld] <= i_io.wdata[0];
    end

    always_ff @(posedge i_clk_sys) begin
        for (int ld = 0; ld < NUM_LD; ld++) begin
            if (!i_rst_n || i_soft_rst) begin
                irq_sel_reg[ld] <= (ld == LD_FDC) ? IRQ_RST_FDC : IRQ_RST;
                dma_sel_reg[ld] <= (ld == LD_FDC) ? DMA_RST_FDC : DMA_RST;
            end else if (dat_wr && ld_ok && cur_ld == ld[2:0]) begin
                if (index_reg == IDX_IRQ)
                    irq_sel_reg[ld] <= i_io.wdata[3:0];
                if (index_reg == IDX_DMA)
                    dma_sel_reg[ld] <= i_io.wdata[2:0];
            end
        end
    end

    // bases survive soft reset; keyboard has no base at all
    always_ff @(posedge i_clk_sys) begin
        for (int ld = 0; ld < NUM_LD; ld++) begin
            if (!i_rst_n)
                base_reg[ld] <= BASE_RST;
            else if (dat_wr && ld_reloc && cur_ld == ld[2:0]) begin
                if (index_reg == IDX_BASE_HI)
                    base_reg[ld][11:8] <= i_io.wdata[3:0];
                if (index_reg == IDX_BASE_LO)
                    base_reg[ld][7:0] <= i_io.wdata;
            end
        end
    end

    // ************************************************************
    // register reads
    // ************************************************************
    logic [7:0] rd_data;
    always_comb begin
        rd_data = 8'h00;
        if (!i_io.addr[0])
            rd_data = index_reg;
        else if (index_reg == IDX_LDN)
            rd_data = {4'h0, ldn_reg};
        else if (index_reg == IDX_OSC)
            rd_data = osc_reg;
        else if (index_reg == IDX_CFG_LO)
            rd_data = cfg_base_reg[7:0];
        else if (index_reg == IDX_CFG_HI)
            rd_data = cfg_base_reg[15:8];
        else if (ld_ok && index_reg == IDX_ACT)
            rd_data = {7'h00, act_reg[cur_ld]};
        else if (ld_reloc && index_reg == IDX_BASE_HI)
            rd_data = {4'h0, base_reg[cur_ld][11:8]};
        else if (ld_reloc && index_reg == IDX_BASE_LO)
            rd_data = base_reg[cur_ld][7:0];
        else if (ld_ok && index_reg == IDX_IRQ)
            rd_data = {4'h0, irq_sel_reg[cur_ld]};
        else if (ld_ok && index_reg == IDX_DMA)
            rd_data = {5'h00, dma_sel_reg[cur_ld]};
    end

    // ************************************************************
    // per-device gates
    // ************************************************************
    logic [7:0] live;
    logic [7:0] irq_en;
    logic [7:0] dma_en;
    wire  ecp_irq_on = (i_gates.ecp_mode == ECP_FIFO) || (i_gates.ecp_mode == ECP_ECP)
                    || (i_gates.ecp_mode == ECP_TEST);
    wire  fdc_gate   = i_gates.floppy_dma_irq_gate && !i_gates.fdc_power_down;
    wire  par_irq    = i_gates.ecp_active
                     ? ((ecp_irq_on || i_gates.parallel_irq_enable)
                        && !i_gates.ecp_service_interrupt)
                     : i_gates.parallel_irq_enable;

    always_comb begin
        for (int ld = 0; ld < NUM_LD; ld++)
            live[ld] = act_reg[ld] && IMPL_LD[ld]
                    && ((ld == LD_KBD) || base_ok(ld, base_reg[ld]));
        irq_en           = 8'h00;
        dma_en           = 8'h00;
        irq_en[LD_FDC]   = live[LD_FDC] && fdc_gate;
        dma_en[LD_FDC]   = live[LD_FDC] && fdc_gate;
        irq_en[LD_PAR]   = live[LD_PAR] && par_irq;
        dma_en[LD_PAR]   = live[LD_PAR] && i_gates.ecp_active && i_gates.ecp_dma_enable;
        irq_en[LD_UART1] = live[LD_UART1] && (|i_gates.uart1_int_enable_reg)
                        && i_gates.uart1_aux_output_two;
        irq_en[LD_UART2] = live[LD_UART2] && (|i_gates.uart2_int_enable_reg)
                        && i_gates.uart2_aux_output_two;
        irq_en[LD_KBD]   = live[LD_KBD];
    end

    // ************************************************************
    // routing onto pins
    // ************************************************************
    logic [15:0] use_irq [NUM_LD];
    logic [15:0] lvl_irq [NUM_LD];
    logic [3:0]  use_dma [NUM_LD];
    logic [3:0]  lvl_dma [NUM_LD];

    for (genvar g = 0; g < NUM_LD; g++) begin : g_slice
        idr_route_slice u_slice (
            .i_irq_sel (irq_sel_reg[g]),
            .i_irq_en  (irq_en[g]),
            .i_irq_req (i_dev_irq[g]),
            .i_dma_sel (dma_sel_reg[g]),
            .i_dma_en  (dma_en[g]),
            .i_dma_req (i_dev_drq[g]),
            .o_irq_use (use_irq[g]),
            .o_irq_lvl (lvl_irq[g]),
            .o_dma_use (use_dma[g]),
            .o_dma_lvl (lvl_dma[g])
        );
    end

    logic [15:0] irq_use_all;
    logic [15:0] irq_lvl_all;
    logic [3:0]  dma_use_all;
    logic [3:0]  dma_lvl_all;
    logic [7:0]  dack_next;
    logic [7:0]  hit_next;
    always_comb begin
        irq_use_all = 16'h0000;
        irq_lvl_all = 16'h0000;
        dma_use_all = 4'h0;
        dma_lvl_all = 4'h0;
        for (int ld = 0; ld < NUM_LD; ld++) begin
            irq_use_all = irq_use_all | use_irq[ld];
            irq_lvl_all = irq_lvl_all | lvl_irq[ld];
            dma_use_all = dma_use_all | use_dma[ld];
            dma_lvl_all = dma_lvl_all | lvl_dma[ld];
            dack_next[ld] = |(use_dma[ld][3:1] & ~i_dack_n);
            hit_next[ld]  = (i_io.rd || i_io.wr) && live[ld] && RELOC_LD[ld]
                         && addr_hit(i_io.addr, base_reg[ld], SPAN8_MASK, qual16);
        end
        hit_next[LD_KBD] = (i_io.rd || i_io.wr) && live[LD_KBD]
                        && (addr_hit(i_io.addr, KBD_DATA[11:0], 12'h000, qual16)
                         || addr_hit(i_io.addr, KBD_CMD[11:0], 12'h000, qual16));
    end

    // in parallel irq mode only some levels exist; level two yields to smi
    wire [15:0] irq_avail = (i_serial_irq_mode ? IRQ_ALL_MASK : IRQ_PAR_MASK)
                          & ~(i_smi_enable ? IRQ_SMI_BIT : 16'h0000);
    wire [15:0] irq_drive = irq_use_all & irq_avail;

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_irq              <= 16'h0000;
            o_irq_oe_n         <= 16'hFFFF;
            o_dma_request_pin  <= 3'h0;
            o_dma_request_oe_n <= 3'h7;
            o_sys_mgmt_int_n   <= 1'b1;
            o_dev_dack         <= 8'h00;
            o_dev_hit          <= 8'h00;
            o_io_rdata         <= 8'h00;
            o_io_rdata_valid   <= 1'b0;
        end else begin
            o_irq              <= irq_lvl_all & irq_drive;
            o_irq_oe_n         <= ~irq_drive;
            o_dma_request_pin  <= dma_lvl_all[3:1];
            o_dma_request_oe_n <= ~dma_use_all[3:1];
            o_sys_mgmt_int_n   <= !(i_smi_enable && i_smi_req);
            o_dev_dack         <= dack_next;
            o_dev_hit          <= hit_next;
            o_io_rdata         <= cfg_rd ? rd_data : 8'h00;
            o_io_rdata_valid   <= cfg_rd;
        end
    end

    assign o_dev_active = act_reg;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);

    sequence rst_release;
        !i_rst_n ##1 i_rst_n;
    endsequence
    sequence fdc_gate_low;
        !fdc_gate [*2];
    endsequence

    // these watch the reset release itself, so the default disable must not abort them
    irq_reset_val_a: assert property (@(posedge i_clk_sys) disable iff (1'b0) rst_release
        |-> irq_sel_reg[LD_FDC] == 4'h6 && irq_sel_reg[LD_PAR] == 4'h0)
        else $error("irq select reset value wrong");
    dma_reset_val_a: assert property (@(posedge i_clk_sys) disable iff (1'b0) rst_release
        |-> dma_sel_reg[LD_FDC] == 3'h2 && dma_sel_reg[LD_UART1] == 3'h4)
        else $error("dma select reset value wrong");
    strap_port_a: assert property (@(posedge i_clk_sys) disable iff (1'b0) rst_release
        |=> cfg_base_reg == ($past(i_config_port_strap) ? 16'h0370 : 16'h03F0))
        else $error("config port not taken from strap");
    level_zero_a: assert property (o_irq_oe_n[0] && !o_irq[0])
        else $error("level zero driven");
    par_mode_mask_a: assert property (!i_serial_irq_mode |=> (~o_irq_oe_n & 16'hE307) == 16'h0000)
        else $error("unavailable irq level driven in parallel mode");
    fdc_gate_off_a: assert property (fdc_gate_low |-> !o_dev_dack[LD_FDC])
        else $error("floppy dack passed while gated");
    dma_idle_a: assert property ((dma_sel_reg[LD_FDC][2] && dma_sel_reg[LD_PAR][2])
        |=> o_dma_request_oe_n == 3'h7)
        else $error("dma pin driven with no channel selected");
    undriven_low_a: assert property (##1 (o_irq & o_irq_oe_n) == 16'h0000)
        else $error("floating irq pin carries a level");
    smi_follow_a: assert property (i_smi_enable && i_smi_req |=> !o_sys_mgmt_int_n)
        else $error("smi not asserted low");
    unused_idx_a: assert property (cfg_rd && i_io.addr[0] && index_reg == 8'h75
        |=> o_io_rdata_valid && o_io_rdata == 8'h00)
        else $error("unimplemented index not reading zero");
    kbd_fixed_a: assert property (act_reg[LD_KBD] && i_io.rd && i_io.addr == 16'h0064
        |=> o_dev_hit[LD_KBD])
        else $error("keyboard command port not decoded");

endmodule

// file: tb/idr_sys_model.sv
/* system irq and dma controller stand-in facing the routing pins.
   assumes: pins change on i_clk_sys; lines have no pulls. */
`timescale 1ns/100ps
module idr_sys_model (
    input  wire logic        i_clk_sys,
    input  wire logic [15:0] i_irq,
    input  wire logic [15:0] i_irq_oe_n,
    input  wire logic [3:1]  i_drq,
    input  wire logic [3:1]  i_drq_oe_n,
    output logic      [15:0] o_irq_line,
    output logic      [3:1]  o_dack_n
);
    logic [3:1]  drq_line;
    // no pulls: a floated line shows the inverse of the pin value, never a stale level
    assign o_irq_line = (~i_irq_oe_n & i_irq) | (i_irq_oe_n & ~i_irq);
    assign drq_line   = (~i_drq_oe_n & i_drq) | (i_drq_oe_n & ~i_drq);
    always_ff @(posedge i_clk_sys) begin
        o_dack_n <= ~(drq_line & ~i_drq_oe_n);
    end
endmodule

// file: tb/testbench.sv
/* self-checking bench for idr_routing.
   assumes: strap low so config port sits at its low address. */
`timescale 1ns/100ps
module testbench;
    import idr_pkg::*;
    logic        i_clk_sys, i_rst_n, smi_en, valid, smi_n, soft_rst, ser_mode;
    idr_io_t     io;
    idr_gate_t   gates;
    logic [7:0]  dev_irq, dev_drq, rdata, dack, r, hit, active;
    logic [15:0] irq, irq_oe_n, irq_line;
    logic [3:1]  drq, drq_oe_n, dack_n;
    int          bad_count, cmp_count;
    idr_routing u_dut (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_soft_rst(soft_rst),
        .i_io(io), .i_gates(gates), .i_config_port_strap(1'b0), .i_serial_irq_mode(ser_mode),
        .i_smi_enable(smi_en), .i_smi_req(smi_en), .i_dev_irq(dev_irq), .i_dev_drq(dev_drq),
        .i_dack_n(dack_n), .o_io_rdata(rdata), .o_io_rdata_valid(valid), .o_irq(irq),
        .o_irq_oe_n(irq_oe_n), .o_dma_request_pin(drq), .o_dma_request_oe_n(drq_oe_n),
        .o_sys_mgmt_int_n(smi_n), .o_dev_dack(dack), .o_dev_hit(hit), .o_dev_active(active));
    idr_sys_model u_sys (.i_clk_sys(i_clk_sys), .i_irq(irq), .i_irq_oe_n(irq_oe_n),
        .i_drq(drq), .i_drq_oe_n(drq_oe_n), .o_irq_line(irq_line), .o_dack_n(dack_n));
    initial begin
        i_clk_sys = 1'b0;
        forever #50 i_clk_sys = ~i_clk_sys;
    end
    task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
        cmp_count++;
        if (s !== e) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic io_op(input logic [15:0] a, input logic [7:0] d, input logic w);
        @(posedge i_clk_sys);
        io <= '{addr: a, wdata: d, wr: w, rd: !w};
        @(posedge i_clk_sys);
        io <= '0;
    endtask
    task automatic cfg_wr(input logic [7:0] idx, input logic [7:0] d);
        io_op(CFG_PORT_LO, idx, 1'b1);
        io_op(CFG_PORT_LO + 16'h0001, d, 1'b1);
    endtask
    task automatic cfg_rd(input logic [7:0] idx, output logic [7:0] d);
        int n;
        io_op(CFG_PORT_LO, idx, 1'b1);
        io_op(CFG_PORT_LO + 16'h0001, 8'h00, 1'b0);
        for (n = 0; n < 4; n++) begin
            #1;
            if (valid === 1'b1) break;
            @(posedge i_clk_sys);
        end
        if (n == 4) begin
            bad_count++;
            end_of_test();
        end
        d = rdata;
    endtask
    task automatic settle();
        repeat (2) @(posedge i_clk_sys);
        #1;
    endtask
    task automatic t_reset();
        chk("irq_oe_n", irq_oe_n, 16'hFFFF);
        chk("drq_oe_n", {13'h0, drq_oe_n}, 16'h0007);
        cfg_wr(IDX_LDN, 8'h00);
        cfg_rd(IDX_IRQ, r);
        chk("fdc irq sel", {8'h00, r}, 16'h0006);
        cfg_rd(IDX_DMA, r);
        chk("fdc dma sel", {8'h00, r}, 16'h0002);
        cfg_wr(IDX_LDN, 8'h04);
        cfg_rd(IDX_IRQ, r);
        chk("uart irq sel", {8'h00, r}, 16'h0000);
        cfg_rd(IDX_DMA, r);
        chk("uart dma sel", {8'h00, r}, 16'h0004);
        cfg_wr(8'h75, 8'hA5);
        cfg_rd(8'h75, r);
        chk("idx 75", {8'h00, r}, 16'h0000);
    endtask
    task automatic t_floppy();
        cfg_wr(IDX_LDN, 8'h00);
        cfg_wr(IDX_BASE_HI, 8'h03);
        cfg_wr(IDX_BASE_LO, 8'hF0);
        cfg_wr(IDX_ACT, 8'h01);
        @(posedge i_clk_sys);
        gates.floppy_dma_irq_gate <= 1'b1;
        dev_irq[0] <= 1'b1;
        dev_drq[0] <= 1'b1;
        settle();
        chk("fdc irq6", {irq[6], irq_oe_n[6]}, 16'h0002);
        chk("fdc drq2", {drq[2], drq_oe_n[2]}, 16'h0002);
        settle();
        chk("fdc dack", {15'h0, dack[0]}, 16'h0001);
        cfg_wr(IDX_DMA, 8'h04);
        settle();
        chk("fdc dma none", {13'h0, drq_oe_n}, 16'h0007);
        cfg_wr(IDX_DMA, 8'h02);
        @(posedge i_clk_sys);
        gates.fdc_power_down <= 1'b1;
        settle();
        chk("fdc pd oe", {irq_oe_n[6], drq_oe_n[2]}, 16'h0003);
        @(posedge i_clk_sys);
        gates.fdc_power_down <= 1'b0;
        gates.floppy_dma_irq_gate <= 1'b0;
        settle();
        chk("fdc gate oe", {irq_oe_n[6], drq_oe_n[2]}, 16'h0003);
    endtask
    task automatic t_uart2();
        cfg_wr(IDX_LDN, 8'h05);
        cfg_wr(IDX_BASE_HI, 8'h02);
        cfg_wr(IDX_BASE_LO, 8'hF8);
        cfg_wr(IDX_IRQ, 8'h03);
        cfg_wr(IDX_ACT, 8'h01);
        @(posedge i_clk_sys);
        gates.uart2_int_enable_reg <= 4'h8;
        dev_irq[5] <= 1'b1;
        smi_en <= 1'b1;
        settle();
        chk("uart uart_aux_output_two low", {15'h0, irq_oe_n[3]}, 16'h0001);
        chk("smi low", {15'h0, smi_n}, 16'h0000);
        @(posedge i_clk_sys);
        gates.uart2_aux_output_two <= 1'b1;
        settle();
        chk("uart irq3", {irq[3], irq_oe_n[3]}, 16'h0002);
    endtask
    task automatic t_levels();
        cfg_wr(IDX_IRQ, 8'h02);
        settle();
        chk("lvl2 smi on", {15'h0, irq_oe_n[2]}, 16'h0001);
        @(posedge i_clk_sys);
        smi_en <= 1'b0;
        settle();
        chk("lvl2 smi off", {irq_line[2], irq_oe_n[2], smi_n}, 16'h0005);
        @(posedge i_clk_sys);
        ser_mode <= 1'b0;
        settle();
        chk("lvl2 parallel", {15'h0, irq_oe_n[2]}, 16'h0001);
        cfg_wr(IDX_IRQ, 8'h0A);
        settle();
        chk("lvl10 parallel", {irq_line[10], irq_oe_n[10]}, 16'h0002);
        @(posedge i_clk_sys);
        ser_mode <= 1'b1;
    endtask
    task automatic t_kbd();
        cfg_wr(IDX_LDN, 8'h07);
        cfg_wr(IDX_ACT, 8'h01);
        #1;
        chk("active", {8'h00, active}, 16'h00A1);
        io_op(KBD_CMD, 8'h00, 1'b0);
        #1;
        chk("kbd hit", {8'h00, hit}, 16'h0080);
        io_op(16'h02FF, 8'h00, 1'b1);
        #1;
        chk("uart2 hit", {8'h00, hit}, 16'h0020);
    endtask
    task automatic t_soft();
        cfg_wr(IDX_LDN, 8'h05);
        @(posedge i_clk_sys);
        soft_rst <= 1'b1;
        @(posedge i_clk_sys);
        soft_rst <= 1'b0;
        cfg_rd(IDX_IRQ, r);
        chk("soft irq sel", {8'h00, r}, 16'h0000);
        chk("soft active", {8'h00, active}, 16'h0000);
    endtask
    initial begin
        i_rst_n = 1'b0;
        smi_en = 1'b0;
        soft_rst = 1'b0;
        ser_mode = 1'b1;
        io = '0;
        gates = '0;
        dev_irq = 8'h00;
        dev_drq = 8'h00;
        repeat (3) @(posedge i_clk_sys);
        i_rst_n <= 1'b1;
        settle();
        t_reset();
        t_floppy();
        t_uart2();
        t_levels();
        t_kbd();
        t_soft();
        end_of_test();
    end
endmodule
